/* rtl/cutoff_defs.svh */
// timing, register map and reset values of the torque cutoff monitor
`ifndef CUTOFF_DEFS_SVH
`define CUTOFF_DEFS_SVH

// clock and timing
`define CUT_CLK_HZ           25000000
`define CUT_MISMATCH_MS      1000
`define CUT_BOTH_OFF_MS      10
`define CUT_RESP_MS          20
`define CUT_MISMATCH_CYC     (`CUT_MISMATCH_MS * (`CUT_CLK_HZ / 1000))
`define CUT_BOTH_OFF_CYC     (`CUT_BOTH_OFF_MS * (`CUT_CLK_HZ / 1000))
`define CUT_RESP_CYC         (`CUT_RESP_MS * (`CUT_CLK_HZ / 1000))

// register offsets
`define CUT_OFS_STATUS       8'h00
`define CUT_OFS_FAULT_CODE   8'h04
`define CUT_OFS_CONFIG       8'h08
`define CUT_OFS_CONTROL      8'h0c
`define CUT_OFS_IRQ_STATUS   8'h10
`define CUT_OFS_IRQ_MASK     8'h14

// status word fields
`define CUT_ST_READY_BIT     0
`define CUT_ST_CHA_BIT       1
`define CUT_ST_CHB_BIT       2
`define CUT_ST_CONTACT_BIT   3
`define CUT_ST_FAULT_LSB     4

// configuration: tens digit selects contact latching
`define CUT_CFG_RESET        16'h0010
`define CUT_CFG_DIGIT_LSB    4
`define CUT_CFG_DIGIT_NOLAT  4'h1
`define CUT_CFG_DIGIT_LATCH  4'h2
`define CUT_CTRL_RESET_BIT   0

// fault codes, reported as plain numbers
`define CUT_CODE_NONE        16'h0000
`define CUT_CODE_BOTH_OFF    16'h01f4
`define CUT_CODE_A_LOSS      16'h01f5
`define CUT_CODE_B_LOSS      16'h01f6
`define CUT_CODE_DIAG        16'h01f7

// interrupt status bits
`define CUT_IRQ_WIDTH        5
`define CUT_IRQ_READY_LOST   4
`endif

/* rtl/cutoff_pkg.sv */
// types shared by the torque cutoff monitor
package cutoff_pkg;
  typedef struct packed {
    logic       diag;
    logic       b_loss;
    logic       a_loss;
    logic       both_off;
  } fault_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_READY  = 2'b00,
    ST_CUTOFF = 2'b01,
    ST_FAULT  = 2'b11
  } mon_state_t;
endpackage

/* rtl/pin_sync.sv */
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // pins and synchronised levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

/* rtl/interval_timer.sv */
// counts cycles while run is high; expired once the limit is reached
`timescale 1ns/1ps
module interval_timer #(
  parameter int W     = 26,
  parameter int LIMIT = 1000
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // control
  input  wire logic run,
  output logic      expired
);
  localparam logic [W-1:0] LIM = W'(LIMIT);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (!run) begin
      cnt_ff <= '0;
    end else if (cnt_ff != LIM) begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  assign expired = run && (cnt_ff == LIM);
endmodule

/* rtl/torque_cutoff_monitor.sv */
// dual channel torque cutoff monitor with fault classification
//
// Overview of operation
// - both channels on and no fault: ready, status bit 0 set, gates allowed
// - either channel off forces every gate drive signal off on the third clock edge after the pin falls
// - gates must read back off within 20 ms of a cutoff demand or fault
// - channel b off over 1 s with a on posts fault 502
// - channel a off over 1 s with b on posts fault 501
// - both channels off over 10 ms posts fault 500
// - self-diagnostic failure of the cutoff path posts fault 503
// - any cutoff fault switches all gate drive signals off
// - fault 500 reset accepted only while both channels are on
// - faults 501, 502 and 503 clear only at power-on reset
// - config tens digit 1 selects non-latching, 2 latching status contact
// - latching contact keeps its fault state after the fault clears
// - contact open without fault, closed on 500, open on 501-503
`timescale 1ns/1ps
`include "cutoff_defs.svh"
module torque_cutoff_monitor #(
  parameter int GATES        = 6,
  parameter int MISMATCH_CYC = `CUT_MISMATCH_CYC,
  parameter int BOTH_OFF_CYC = `CUT_BOTH_OFF_CYC,
  parameter int RESP_CYC     = `CUT_RESP_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // safety enable, alarm reset and diagnostic pins
  input  wire logic                 safety_enable_channel_a,
  input  wire logic                 safety_enable_channel_b,
  input  wire logic                 alarm_reset_input,
  input  wire logic                 diag_fail_in,
  // power stage
  input  wire logic [GATES-1:0]     pwm_in,
  input  wire logic [GATES-1:0]     gate_fb,
  output logic      [GATES-1:0]     gate_out,
  // status
  output logic                      drive_ready,
  output logic                      status_contact_closed,
  output logic                      irq,
  // register port
  input  wire cutoff_pkg::bus_req_t bus_req,
  output logic      [31:0]          rd_data
);
  localparam int TW = 26;

  // synchronised pins
  logic [3:0]                 pins_sync;
  logic                       ch_a;
  logic                       ch_b;
  logic                       arst_lvl;
  logic [GATES-1:0]           fb_sync;
  logic                       diag_lvl;
  logic                       arst_prev_ff;

  // timers
  logic                       a_only_low;
  logic                       b_only_low;
  logic                       both_low;
  logic                       a_exp;
  logic                       b_exp;
  logic                       both_exp;
  logic                       resp_run;
  logic                       resp_exp;

  // faults and state
  cutoff_pkg::fault_t         fault_ff;
  cutoff_pkg::fault_t         fault_prev_ff;
  cutoff_pkg::fault_t         fault_new;
  cutoff_pkg::mon_state_t     state_ff;
  cutoff_pkg::mon_state_t     nxt_state;
  logic                       any_fault;
  logic                       torque_en;
  logic                       reset_req;
  logic                       sw_reset;
  logic [GATES-1:0]           gate_ff;
  logic                       ready_ff;
  logic                       contact_ff;
  logic                       nxt_contact;
  logic                       latch_mode;

  // registers
  logic [15:0]                cfg_ff;
  logic [`CUT_IRQ_WIDTH-1:0]  irq_st_ff;
  logic [`CUT_IRQ_WIDTH-1:0]  irq_mask_ff;
  logic [`CUT_IRQ_WIDTH-1:0]  irq_evt;
  logic [`CUT_IRQ_WIDTH-1:0]  irq_w1c;
  logic [31:0]                rd_ff;
  logic [31:0]                nxt_rd;
  logic [31:0]                status_word;
  logic [15:0]                fault_code;

  // pin synchronisers
  pin_sync #(
    .W (4)
  ) u_sync_ctl (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .pin_in   ({diag_fail_in, alarm_reset_input,
                safety_enable_channel_b, safety_enable_channel_a}),
    .sync_out (pins_sync)
  );

  pin_sync #(
    .W (GATES)
  ) u_sync_fb (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .pin_in   (gate_fb),
    .sync_out (fb_sync)
  );

  assign ch_a     = pins_sync[0];
  assign ch_b     = pins_sync[1];
  assign arst_lvl = pins_sync[2];
  assign diag_lvl = pins_sync[3];

  // channel loss classification
  assign a_only_low = !ch_a && ch_b;
  assign b_only_low = ch_a && !ch_b;
  assign both_low   = !ch_a && !ch_b;

  interval_timer #(
    .W     (TW),
    .LIMIT (MISMATCH_CYC)
  ) u_tmr_a (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (a_only_low),
    .expired (a_exp)
  );

  interval_timer #(
    .W     (TW),
    .LIMIT (MISMATCH_CYC)
  ) u_tmr_b (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (b_only_low),
    .expired (b_exp)
  );

  interval_timer #(
    .W     (TW),
    .LIMIT (BOTH_OFF_CYC)
  ) u_tmr_both (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (both_low),
    .expired (both_exp)
  );

  // gate readback watchdog
  assign resp_run = !torque_en && (|fb_sync);

  interval_timer #(
    .W     (TW),
    .LIMIT (RESP_CYC)
  ) u_tmr_resp (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (resp_run),
    .expired (resp_exp)
  );

  // fault reset request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      arst_prev_ff <= 1'b0;
    end else begin
      arst_prev_ff <= arst_lvl;
    end
  end

  assign sw_reset  = bus_req.wr && (bus_req.addr == `CUT_OFS_CONTROL)
                     && bus_req.wdata[`CUT_CTRL_RESET_BIT];
  assign reset_req = sw_reset || (arst_lvl && !arst_prev_ff);

  // fault flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_ff <= '0;
    end else begin
      if (both_exp) begin
        fault_ff.both_off <= 1'b1;
      end else if (reset_req && ch_a && ch_b) begin
        fault_ff.both_off <= 1'b0;
      end
      if (a_exp) begin
        fault_ff.a_loss <= 1'b1;
      end
      if (b_exp) begin
        fault_ff.b_loss <= 1'b1;
      end
      if (diag_lvl || resp_exp) begin
        fault_ff.diag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fault_prev_ff <= '0;
    end else begin
      fault_prev_ff <= fault_ff;
    end
  end

  assign fault_new = fault_ff & ~fault_prev_ff;
  assign any_fault = |fault_ff;

  // torque permission
  assign torque_en = ch_a && ch_b && !any_fault;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_ff <= '0;
    end else if (torque_en) begin
      gate_ff <= pwm_in;
    end else begin
      gate_ff <= '0;
    end
  end

  assign gate_out = gate_ff;

  // monitor state
  always_comb begin
    case (state_ff)
      cutoff_pkg::ST_READY: begin
        if (any_fault) begin
          nxt_state = cutoff_pkg::ST_FAULT;
        end else if (!(ch_a && ch_b)) begin
          nxt_state = cutoff_pkg::ST_CUTOFF;
        end else begin
          nxt_state = cutoff_pkg::ST_READY;
        end
      end
      cutoff_pkg::ST_CUTOFF: begin
        if (any_fault) begin
          nxt_state = cutoff_pkg::ST_FAULT;
        end else if (ch_a && ch_b) begin
          nxt_state = cutoff_pkg::ST_READY;
        end else begin
          nxt_state = cutoff_pkg::ST_CUTOFF;
        end
      end
      cutoff_pkg::ST_FAULT: begin
        if (any_fault) begin
          nxt_state = cutoff_pkg::ST_FAULT;
        end else begin
          nxt_state = cutoff_pkg::ST_CUTOFF;
        end
      end
      default: begin
        nxt_state = cutoff_pkg::ST_CUTOFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= cutoff_pkg::ST_CUTOFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= torque_en;
    end
  end

  assign drive_ready = ready_ff;

  // safety status contact
  assign latch_mode = cfg_ff[`CUT_CFG_DIGIT_LSB +: 4] == `CUT_CFG_DIGIT_LATCH;

  always_comb begin
    nxt_contact = contact_ff;
    if (fault_ff.a_loss || fault_ff.b_loss || fault_ff.diag) begin
      nxt_contact = 1'b0;
    end else if (fault_ff.both_off) begin
      nxt_contact = 1'b1;
    end else if (!latch_mode) begin
      nxt_contact = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      contact_ff <= 1'b0;
    end else begin
      contact_ff <= nxt_contact;
    end
  end

  assign status_contact_closed = contact_ff;

  // fault code, highest number wins
  always_comb begin
    if (fault_ff.diag) begin
      fault_code = `CUT_CODE_DIAG;
    end else if (fault_ff.b_loss) begin
      fault_code = `CUT_CODE_B_LOSS;
    end else if (fault_ff.a_loss) begin
      fault_code = `CUT_CODE_A_LOSS;
    end else if (fault_ff.both_off) begin
      fault_code = `CUT_CODE_BOTH_OFF;
    end else begin
      fault_code = `CUT_CODE_NONE;
    end
  end

  // output status word
  always_comb begin
    status_word                              = '0;
    status_word[`CUT_ST_READY_BIT]           = ready_ff;
    status_word[`CUT_ST_CHA_BIT]             = ch_a;
    status_word[`CUT_ST_CHB_BIT]             = ch_b;
    status_word[`CUT_ST_CONTACT_BIT]         = contact_ff;
    status_word[`CUT_ST_FAULT_LSB +: 4]      = fault_ff;
  end

  // configuration register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= `CUT_CFG_RESET;
    end else if (bus_req.wr && (bus_req.addr == `CUT_OFS_CONFIG)) begin
      cfg_ff <= bus_req.wdata[15:0];
    end
  end

  // interrupts: set beats write-one-to-clear
  assign irq_evt = {ready_ff && !torque_en, fault_new};
  assign irq_w1c = (bus_req.wr && (bus_req.addr == `CUT_OFS_IRQ_STATUS))
                   ? bus_req.wdata[`CUT_IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_st_ff <= '0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~irq_w1c) | irq_evt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_mask_ff <= '0;
    end else if (bus_req.wr && (bus_req.addr == `CUT_OFS_IRQ_MASK)) begin
      irq_mask_ff <= bus_req.wdata[`CUT_IRQ_WIDTH-1:0];
    end
  end

  assign irq = |(irq_st_ff & irq_mask_ff);

  // read decode
  always_comb begin
    nxt_rd = '0;
    if (!bus_req.rd) begin
      nxt_rd = '0;
    end else if (bus_req.addr == `CUT_OFS_STATUS) begin
      nxt_rd = status_word;
    end else if (bus_req.addr == `CUT_OFS_FAULT_CODE) begin
      nxt_rd = {16'h0000, fault_code};
    end else if (bus_req.addr == `CUT_OFS_CONFIG) begin
      nxt_rd = {16'h0000, cfg_ff};
    end else if (bus_req.addr == `CUT_OFS_IRQ_STATUS) begin
      nxt_rd = {27'h0000000, irq_st_ff};
    end else if (bus_req.addr == `CUT_OFS_IRQ_MASK) begin
      nxt_rd = {27'h0000000, irq_mask_ff};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_ff <= '0;
    end else begin
      rd_ff <= nxt_rd;
    end
  end

  assign rd_data = rd_ff;
endmodule

/* verification/safety_relay_model.sv */
// safety relay model driving the two enable channels
`timescale 1ns/1ps
module safety_relay_model (
  // clock
  input  wire logic       clk_sys,
  // bench commands: want is {b, a}, lag delays channel a
  input  wire logic [1:0] want,
  input  wire logic [7:0] lag,
  // enable channels
  output logic            chan_a,
  output logic            chan_b
);
  logic [7:0] wait_ff;
  initial begin
    chan_a  = 1'b1;
    chan_b  = 1'b1;
    wait_ff = 8'h00;
  end
  // lag stays far below the mismatch limit
  always @(posedge clk_sys) begin
    chan_b <= want[1];
    if (chan_a == want[0]) begin
      wait_ff <= 8'h00;
    end else if (wait_ff >= lag) begin
      chan_a <= want[0];
    end else begin
      wait_ff <= wait_ff + 8'h01;
    end
  end
endmodule

/* verification/cutoff_props.sv */
// port assertions of the torque cutoff monitor
`timescale 1ns/1ps
module cutoff_props #(
  parameter int GATES        = 6,
  parameter int MISMATCH_CYC = 50,
  parameter int BOTH_OFF_CYC = 10
) (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  // pins
  input wire logic                 safety_enable_channel_a,
  input wire logic                 safety_enable_channel_b,
  input wire logic                 alarm_reset_input,
  input wire logic                 diag_fail_in,
  input wire logic [GATES-1:0]     pwm_in,
  // outputs and bus
  input wire logic [GATES-1:0]     gate_out,
  input wire logic                 drive_ready,
  input wire cutoff_pkg::bus_req_t bus_req
);
  localparam logic [7:0] MM_LIM = 8'(MISMATCH_CYC + 4);
  localparam logic [7:0] BO_LIM = 8'(BOTH_OFF_CYC + 4);
  logic [7:0] a_cnt_ff, b_cnt_ff, ab_cnt_ff;
  logic       mm_seen_ff, bo_seen_ff, diag_seen_ff;
  wire        ch_a = safety_enable_channel_a;
  wire        ch_b = safety_enable_channel_b;
  // a reset request only counts while both channels are on
  wire        clr  = (alarm_reset_input || (bus_req.wr && bus_req.addr == 8'h0c
                      && bus_req.wdata[0])) && ch_a && ch_b;
  // consecutive cycles of each low pattern at the pins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      a_cnt_ff  <= 8'h00;
      b_cnt_ff  <= 8'h00;
      ab_cnt_ff <= 8'h00;
    end else begin
      a_cnt_ff  <= (!ch_a && ch_b) ? a_cnt_ff + 8'h01 : 8'h00;
      b_cnt_ff  <= (ch_a && !ch_b) ? b_cnt_ff + 8'h01 : 8'h00;
      ab_cnt_ff <= (!ch_a && !ch_b) ? ab_cnt_ff + 8'h01 : 8'h00;
    end
  end
  // evidence that a fault must be posted
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mm_seen_ff   <= 1'b0;
      bo_seen_ff   <= 1'b0;
      diag_seen_ff <= 1'b0;
    end else begin
      mm_seen_ff   <= mm_seen_ff || a_cnt_ff == MM_LIM || b_cnt_ff == MM_LIM;
      bo_seen_ff   <= (ab_cnt_ff == BO_LIM) || (bo_seen_ff && !clr);
      diag_seen_ff <= diag_seen_ff || diag_fail_in;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence a_off_s;
    !ch_a [*5];
  endsequence
  sequence b_off_s;
    !ch_b [*5];
  endsequence
  chk_cut_a: assert property (a_off_s |=> gate_out == '0)
    else $error("gates on with channel a off");
  chk_cut_b: assert property (b_off_s |=> gate_out == '0)
    else $error("gates on with channel b off");
  chk_gate_pass: assert property (gate_out != '0 |-> gate_out == $past(pwm_in))
    else $error("gates differ from command");
  // two sync stages and the ready flop: ready reflects the pins three edges back
  chk_ready_both: assert property (drive_ready |-> $past(ch_a, 3) && $past(ch_b, 3))
    else $error("ready with a channel off");
  chk_mismatch_hold: assert property (mm_seen_ff |-> !drive_ready)
    else $error("ready after mismatch fault");
  chk_bothoff_hold: assert property (bo_seen_ff |-> !drive_ready)
    else $error("ready after both off fault");
  chk_diag_hold: assert property ($past(diag_seen_ff, 4) |-> !drive_ready)
    else $error("ready after diagnostic fault");
  chk_fault_gate: assert property (mm_seen_ff || bo_seen_ff |-> gate_out == '0)
    else $error("gates on during fault");
endmodule

/* verification/tb_top.sv */
// self-checking bench of the torque cutoff monitor
`timescale 1ns/1ps
module tb_top;
  localparam int MM = 50;
  localparam int BO = 10;
  localparam int RP = 20;
  logic                 clk_sys, resetn, ch_a, ch_b, drive_ready, irq;
  logic                 alarm_reset_input, diag_fail_in, status_contact_closed;
  logic [1:0]           want;
  logic [7:0]           lag;
  logic [5:0]           pwm_in, gate_fb, gate_out;
  logic [31:0]          rd_data;
  cutoff_pkg::bus_req_t bus_req;
  int                   mismatches = 0;
  int                   samples_checked = 0;

  safety_relay_model u_safety_relay_model (
    .clk_sys(clk_sys), .want(want), .lag(lag), .chan_a(ch_a), .chan_b(ch_b)
  );
  torque_cutoff_monitor #(
    .MISMATCH_CYC(MM), .BOTH_OFF_CYC(BO), .RESP_CYC(RP)
  ) u_torque_cutoff_monitor (
    .clk_sys(clk_sys), .resetn(resetn),
    .safety_enable_channel_a(ch_a), .safety_enable_channel_b(ch_b),
    .alarm_reset_input(alarm_reset_input), .diag_fail_in(diag_fail_in),
    .pwm_in(pwm_in), .gate_fb(gate_fb), .gate_out(gate_out),
    .drive_ready(drive_ready), .status_contact_closed(status_contact_closed),
    .irq(irq), .bus_req(bus_req), .rd_data(rd_data)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    bus_req <= '{addr, data, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    bus_req <= '{addr, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    chk(what, exp, rd_data);
  endtask

  task automatic relay(input logic a, input logic b, input logic [7:0] l);
    @(posedge clk_sys);
    want <= {b, a};
    lag  <= l;
  endtask

  task automatic pulse_alarm();
    @(posedge clk_sys);
    alarm_reset_input <= 1'b1;
    tick(3);
    alarm_reset_input <= 1'b0;
  endtask

  task automatic wait_ready(input logic exp);
    int n;
    n = 0;
    while (drive_ready !== exp && n < 20) begin
      settle(1);
      n++;
    end
    chk("ready", 32'(exp), 32'(drive_ready));
    if (drive_ready !== exp) results();
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
  endtask

  task automatic s_ready();
    wait_ready(1'b1);
    rd(8'h00, 32'h7, "status");
    rd(8'h08, 32'h10, "config");
    rd(8'h18, 32'h0, "unmapped");
    @(posedge clk_sys);
    pwm_in <= 6'h2d;
    settle(3);
    chk("gates", 32'h2d, 32'(gate_out));
    relay(1'b0, 1'b0, 8'd6);
    settle(4);
    relay(1'b1, 1'b1, 8'd0);
    wait_ready(1'b1);
    rd(8'h04, 32'h0, "code");
  endtask

  task automatic s_both_off();
    wr(8'h14, 32'h1f);
    relay(1'b0, 1'b0, 8'd0);
    settle(5);
    chk("gates", 32'h0, 32'(gate_out));
    tick(BO + 6);
    rd(8'h04, 32'h1f4, "code");
    chk("contact", 32'h1, 32'(status_contact_closed));
    rd(8'h10, 32'h11, "irq status");
    chk("irq", 32'h1, 32'(irq));
    wr(8'h14, 32'h0);
    settle(1);
    chk("irq masked", 32'h0, 32'(irq));
    wr(8'h14, 32'h1f);
    wr(8'h10, 32'h1f);
    settle(1);
    chk("irq cleared", 32'h0, 32'(irq));
    pulse_alarm();
    tick(4);
    relay(1'b1, 1'b1, 8'd0);
    tick(10);
    rd(8'h00, 32'h1e, "status");
    wr(8'h0c, 32'h1);
    wait_ready(1'b1);
    rd(8'h04, 32'h0, "code");
    chk("contact", 32'h0, 32'(status_contact_closed));
  endtask

  task automatic s_latch();
    wr(8'h08, 32'h20);
    relay(1'b0, 1'b0, 8'd0);
    tick(BO + 8);
    relay(1'b1, 1'b1, 8'd0);
    tick(4);
    pulse_alarm();
    wait_ready(1'b1);
    chk("latched contact", 32'h1, 32'(status_contact_closed));
  endtask

  task automatic s_loss(input logic a_on, input logic [31:0] code, input logic [31:0] st);
    relay(a_on, !a_on, 8'd0);
    tick(MM + 8);
    relay(1'b1, 1'b1, 8'd0);
    settle(8);
    chk("contact", 32'h0, 32'(status_contact_closed));
    rd(8'h00, st, "status");
    rd(8'h04, code, "code");
    pulse_alarm();
    wr(8'h0c, 32'h1);
    settle(6);
    chk("ready", 32'h0, 32'(drive_ready));
    do_reset();
    wait_ready(1'b1);
  endtask

  task automatic s_diag(input logic use_pin);
    @(posedge clk_sys);
    diag_fail_in <= use_pin;
    gate_fb      <= {5'h0, !use_pin};
    want         <= {use_pin, use_pin};
    tick(RP + 8);
    diag_fail_in <= 1'b0;
    gate_fb      <= 6'h0;
    want         <= 2'b11;
    settle(8);
    chk("gates", 32'h0, 32'(gate_out));
    rd(8'h04, 32'h1f7, "code");
    chk("contact", 32'h0, 32'(status_contact_closed));
    do_reset();
    wait_ready(1'b1);
  endtask

  initial begin
    resetn            = 1'b0;
    want              = 2'b11;
    lag               = 8'h00;
    alarm_reset_input = 1'b0;
    diag_fail_in      = 1'b0;
    pwm_in            = 6'h00;
    gate_fb           = 6'h00;
    bus_req           = '0;
    tick(2);
    resetn <= 1'b1;
    s_ready();
    s_both_off();
    s_latch();
    s_loss(1'b0, 32'h1f5, 32'h26);
    s_loss(1'b1, 32'h1f6, 32'h46);
    s_diag(1'b1);
    s_diag(1'b0);
    results();
  end
endmodule

bind torque_cutoff_monitor cutoff_props #(
  .GATES(GATES), .MISMATCH_CYC(MISMATCH_CYC), .BOTH_OFF_CYC(BOTH_OFF_CYC)
) u_cutoff_props (
  .clk_sys(clk_sys), .resetn(resetn),
  .safety_enable_channel_a(safety_enable_channel_a),
  .safety_enable_channel_b(safety_enable_channel_b),
  .alarm_reset_input(alarm_reset_input), .diag_fail_in(diag_fail_in),
  .pwm_in(pwm_in), .gate_out(gate_out), .drive_ready(drive_ready), .bus_req(bus_req)
);
